//--- logic/dup_pkg.sv
package dup_pkg;

  // ==========================================================
  // register addresses on the 4-bit host address bus
  localparam logic [3:0] ADDR_MODE_A = 4'h0;
  localparam logic [3:0] ADDR_CSR_A = 4'h1;
  localparam logic [3:0] ADDR_CMD_A = 4'h2;
  localparam logic [3:0] ADDR_CHG_AUX = 4'h4;
  localparam logic [3:0] ADDR_IMASK = 4'h5;
  localparam logic [3:0] ADDR_MODE_B = 4'h8;
  localparam logic [3:0] ADDR_CSR_B = 4'h9;
  localparam logic [3:0] ADDR_CMD_B = 4'ha;
  localparam logic [3:0] ADDR_IN_PORT = 4'hd;
  localparam logic [3:0] ADDR_OP_SET = 4'he;
  localparam logic [3:0] ADDR_OP_CLR = 4'hf;

  // ==========================================================
  // field positions and codes
  localparam int MR2_CTS_BIT = 4;
  localparam int ACR_BRG_BIT = 7;
  localparam int ACR_CT_LSB = 4;
  localparam int IMR_CHG_BIT = 7;
  localparam int CMD_MISC_LSB = 4;
  localparam logic [2:0] CT_EXT_CODE = 3'h0;
  localparam logic [2:0] CMD_PTR_RST = 3'h1;
  localparam logic [3:0] CSR_EXT_X16 = 4'he;
  localparam logic [3:0] CSR_EXT_X1 = 4'hf;
  // cycles after release before the synchronised strap is trusted
  localparam logic [1:0] STRAP_FILL = 2'h3;

  // ==========================================================
  // values after reset
  localparam logic [7:0] OPR_RST = 8'h00;
  localparam logic [7:0] ACR_RST = 8'h00;
  localparam logic [7:0] CSR_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [5:0] PIN_IDLE = 6'h3f;
  localparam logic [14:0] BUS_IDLE = 15'h7fff;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [3:0] addr;
    logic [7:0] data;
  } dup_bus_t;

  typedef struct packed {
    logic ct_clk;
    logic ct_sel;
    logic b_rx_clk;
    logic b_rx_sel;
    logic b_rx_x1;
    logic a_tx_clk;
    logic a_tx_sel;
    logic a_tx_x1;
    logic a_rx_clk;
    logic a_rx_sel;
    logic a_rx_x1;
    logic b_tx_clk;
    logic b_tx_sel;
    logic b_tx_x1;
  } dup_ext_clk_t;

  typedef enum logic [1:0] {PH_IDLE, PH_READ, PH_WRITE} dup_phase_t;

endpackage

//--- logic/dup_ports.sv
`timescale 1ns/1ns
module dup_ports (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // host bus pins
  input wire dup_pkg::dup_bus_t bus_in,
  output logic [7:0] bus_data_out,
  output logic bus_data_oe_n,
  // general purpose pins and package strap
  input wire logic [5:0] in_pin,
  input wire logic pkg_reduced,
  output logic [7:0] out_pin_o,
  output logic [7:0] out_pin_oe_n,
  // status routing from the output configuration logic
  input wire logic [7:0] status_sel,
  input wire logic [7:0] status_act,
  // detector tick from the baud generator
  input wire logic baud_tick_38k4,
  // to the serial channels and counter
  output logic chan_a_clear_to_send_n,
  output logic chan_b_clear_to_send_n,
  output dup_pkg::dup_ext_clk_t ext_clk,
  output logic baud_set_sel,
  output logic [2:0] counter_mode,
  output logic in_change_irq
);
  import dup_pkg::*;

  // ==========================================================
  // decoding helpers

  // external clock select codes, both the x16 and the x1 form
  function automatic logic csr_is_ext(input logic [3:0] nib);
    csr_is_ext = (nib == CSR_EXT_X16) || (nib == CSR_EXT_X1);
  endfunction

  // x1 form of the external clock code
  function automatic logic csr_is_x1(input logic [3:0] nib);
    csr_is_x1 = (nib == CSR_EXT_X1);
  endfunction

  // ==========================================================
  // state

  typedef struct packed {
    dup_phase_t phase;
    logic [7:0] output_port_latch;
    logic [7:0] auxiliary_control;
    logic imr_chg;
    logic cts_a_en;
    logic cts_b_en;
    logic [7:0] csr_a;
    logic [7:0] csr_b;
    logic mr_ptr_a;
    logic mr_ptr_b;
    logic [3:0] smp_prev;
    logic smp_valid;
    logic [3:0] delta;
    logic [7:0] rd_data;
    logic drive;
    logic [7:0] pin_o;
    logic [7:0] pin_oe_n;
    logic reduced;
    logic [1:0] strap_cnt;
    logic cts_a_n;
    logic cts_b_n;
    dup_ext_clk_t clk;
    logic irq;
  } dup_state_t;

  dup_state_t st_r;
  dup_state_t st_nxt;

  dup_bus_t bus_s;
  logic [5:0] pin_s;
  logic strap_s;
  logic [5:0] pin_eff;
  logic rd_go;
  logic wr_go;
  logic [3:0] chg_now;

  // ==========================================================
  // synchronisers: the bus and pins come from outside mclk

  dup_sync2 #(
    .W(15),
    .RST_VAL(BUS_IDLE)
  ) u_sync_bus (
    .mclk(mclk),
    .resetn(resetn),
    .d(bus_in),
    .q(bus_s)
  );

  dup_sync2 #(
    .W(7),
    .RST_VAL({1'b0, PIN_IDLE})
  ) u_sync_pin (
    .mclk(mclk),
    .resetn(resetn),
    .d({pkg_reduced, in_pin}),
    .q({strap_s, pin_s})
  );

  // ==========================================================
  // access detection and pin view

  // the reduced package bonds out pin 2 only; others read idle high
  always_comb begin
    if (st_r.reduced) begin
      pin_eff = {3'b111, pin_s[2], 2'b11};
    end else begin
      pin_eff = pin_s;
    end
  end

  // an access starts when chip select and a strobe meet while idle
  assign rd_go = (st_r.phase == PH_IDLE) && !bus_s.cs_n && !bus_s.rd_n;
  assign wr_go = (st_r.phase == PH_IDLE) && !bus_s.cs_n && !bus_s.wr_n
                 && bus_s.rd_n;

  // a pin changed if two successive tick samples differ
  assign chg_now = (baud_tick_38k4 && st_r.smp_valid) ?
                   (pin_eff[3:0] ^ st_r.smp_prev) : NIB_ZERO;

  // ==========================================================
  // next state

  always_comb begin
    st_nxt = st_r;

    // the strap is followed until the synchroniser has filled with the
    // pin level; catching it at the first edge would see the reset value
    if (st_r.strap_cnt != STRAP_FILL) begin
      st_nxt.reduced = strap_s;
      st_nxt.strap_cnt = 2'(st_r.strap_cnt + 2'h1);
    end

    // bus phase: one register action per strobe assertion
    unique case (st_r.phase)
      PH_IDLE: begin
        if (rd_go) begin
          st_nxt.phase = PH_READ;
        end else if (wr_go) begin
          st_nxt.phase = PH_WRITE;
        end
      end
      PH_READ: begin
        if (bus_s.cs_n || bus_s.rd_n) begin
          st_nxt.phase = PH_IDLE;
        end
      end
      PH_WRITE: begin
        if (bus_s.cs_n || bus_s.wr_n) begin
          st_nxt.phase = PH_IDLE;
        end
      end
    endcase

    // read data is latched at the start so it holds for the strobe
    if (rd_go) begin
      st_nxt.drive = 1'b1;
      unique case (bus_s.addr)
        ADDR_CHG_AUX: st_nxt.rd_data = {st_r.delta, pin_eff[3:0]};
        ADDR_IN_PORT: st_nxt.rd_data = {2'b00, pin_eff};
        default: st_nxt.rd_data = BYTE_ZERO;
      endcase
    end else if (st_r.phase == PH_READ && (bus_s.cs_n || bus_s.rd_n)) begin
      st_nxt.drive = 1'b0;
    end

    // register writes
    if (wr_go) begin
      unique case (bus_s.addr)
        ADDR_MODE_A: begin
          // first write after pointer reset lands in mode one
          if (st_r.mr_ptr_a) begin
            st_nxt.cts_a_en = bus_s.data[MR2_CTS_BIT];
          end
          st_nxt.mr_ptr_a = 1'b1;
        end
        ADDR_MODE_B: begin
          if (st_r.mr_ptr_b) begin
            st_nxt.cts_b_en = bus_s.data[MR2_CTS_BIT];
          end
          st_nxt.mr_ptr_b = 1'b1;
        end
        ADDR_CMD_A: begin
          if (bus_s.data[CMD_MISC_LSB +: 3] == CMD_PTR_RST) begin
            st_nxt.mr_ptr_a = 1'b0;
          end
        end
        ADDR_CMD_B: begin
          if (bus_s.data[CMD_MISC_LSB +: 3] == CMD_PTR_RST) begin
            st_nxt.mr_ptr_b = 1'b0;
          end
        end
        ADDR_CSR_A: st_nxt.csr_a = bus_s.data;
        ADDR_CSR_B: st_nxt.csr_b = bus_s.data;
        ADDR_CHG_AUX: st_nxt.auxiliary_control = bus_s.data;
        ADDR_IMASK: st_nxt.imr_chg = bus_s.data[IMR_CHG_BIT];
        ADDR_OP_SET: st_nxt.output_port_latch = st_r.output_port_latch | bus_s.data;
        ADDR_OP_CLR: st_nxt.output_port_latch = st_r.output_port_latch & ~bus_s.data;
        default: begin
          // other addresses belong to the channels and counter
        end
      endcase
    end

    // change detection on pins 0 to 3 only; a read clears the flags
    // but a change seen in the same cycle still survives
    if (rd_go && bus_s.addr == ADDR_CHG_AUX) begin
      st_nxt.delta = chg_now;
    end else begin
      st_nxt.delta = st_r.delta | chg_now;
    end

    // a level held across two ticks is always compared once
    if (baud_tick_38k4) begin
      st_nxt.smp_prev = pin_eff[3:0];
      st_nxt.smp_valid = 1'b1;
    end

    // interrupt needs flag, per-pin enable and global enable
    st_nxt.irq = st_r.imr_chg
                 && |(st_r.delta & st_r.auxiliary_control[3:0]);

    // output pins: inverted latch, or open drain when carrying status
    for (int i = 0; i < 8; i++) begin
      if (status_sel[i]) begin
        st_nxt.pin_o[i] = 1'b0;
        st_nxt.pin_oe_n[i] = !status_act[i];
      end else begin
        st_nxt.pin_o[i] = !st_nxt.output_port_latch[i];
        st_nxt.pin_oe_n[i] = 1'b0;
      end
    end

    // clear-to-send: when not enabled the channel sees it asserted
    if (st_r.reduced) begin
      st_nxt.cts_a_n = 1'b0;
      st_nxt.cts_b_n = 1'b0;
    end else begin
      st_nxt.cts_a_n = st_r.cts_a_en ? pin_eff[0] : 1'b0;
      st_nxt.cts_b_n = st_r.cts_b_en ? pin_eff[1] : 1'b0;
    end

    // external clock routing; a deselected clock is held low
    st_nxt.clk.ct_sel = (st_r.auxiliary_control[ACR_CT_LSB +: 3] == CT_EXT_CODE);
    st_nxt.clk.ct_clk = st_nxt.clk.ct_sel && pin_eff[2];
    st_nxt.clk.b_rx_sel = csr_is_ext(st_r.csr_b[7:4]);
    st_nxt.clk.b_rx_x1 = csr_is_x1(st_r.csr_b[7:4]);
    st_nxt.clk.b_rx_clk = st_nxt.clk.b_rx_sel && pin_eff[2];
    st_nxt.clk.a_tx_sel = !st_r.reduced
                          && csr_is_ext(st_r.csr_a[3:0]);
    st_nxt.clk.a_tx_x1 = csr_is_x1(st_r.csr_a[3:0]);
    st_nxt.clk.a_tx_clk = st_nxt.clk.a_tx_sel && pin_eff[3];
    st_nxt.clk.a_rx_sel = !st_r.reduced
                          && csr_is_ext(st_r.csr_a[7:4]);
    st_nxt.clk.a_rx_x1 = csr_is_x1(st_r.csr_a[7:4]);
    st_nxt.clk.a_rx_clk = st_nxt.clk.a_rx_sel && pin_eff[4];
    st_nxt.clk.b_tx_sel = !st_r.reduced
                          && csr_is_ext(st_r.csr_b[3:0]);
    st_nxt.clk.b_tx_x1 = csr_is_x1(st_r.csr_b[3:0]);
    st_nxt.clk.b_tx_clk = st_nxt.clk.b_tx_sel && pin_eff[5];
  end

  // ==========================================================
  // state register; reset values are constants only

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_r.phase <= PH_IDLE;
      st_r.output_port_latch <= OPR_RST;
      st_r.auxiliary_control <= ACR_RST;
      st_r.imr_chg <= 1'b0;
      st_r.cts_a_en <= 1'b0;
      st_r.cts_b_en <= 1'b0;
      st_r.csr_a <= CSR_RST;
      st_r.csr_b <= CSR_RST;
      st_r.mr_ptr_a <= 1'b0;
      st_r.mr_ptr_b <= 1'b0;
      st_r.smp_prev <= NIB_ZERO;
      st_r.smp_valid <= 1'b0;
      st_r.delta <= NIB_ZERO;
      st_r.rd_data <= BYTE_ZERO;
      st_r.drive <= 1'b0;
      st_r.pin_o <= ~OPR_RST;
      st_r.pin_oe_n <= BYTE_ZERO;
      st_r.reduced <= 1'b0;
      st_r.strap_cnt <= 2'h0;
      st_r.cts_a_n <= 1'b0;
      st_r.cts_b_n <= 1'b0;
      st_r.clk <= '0;
      st_r.irq <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs, all from flip-flops

  assign bus_data_out = st_r.rd_data;
  assign bus_data_oe_n = !st_r.drive;
  assign out_pin_o = st_r.pin_o;
  assign out_pin_oe_n = st_r.pin_oe_n;
  assign chan_a_clear_to_send_n = st_r.cts_a_n;
  assign chan_b_clear_to_send_n = st_r.cts_b_n;
  assign ext_clk = st_r.clk;
  assign baud_set_sel = st_r.auxiliary_control[ACR_BRG_BIT];
  assign counter_mode = st_r.auxiliary_control[ACR_CT_LSB +: 3];
  assign in_change_irq = st_r.irq;

endmodule

//--- logic/dup_sync2.sv
`timescale 1ns/1ns
// two-stage synchroniser; stage one feeds stage two only
module dup_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dup_sync_t;

  dup_sync_t st_r;
  dup_sync_t st_nxt;

  // shift one stage per clock
  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  // constants only under reset
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_r <= {RST_VAL, RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;

endmodule

//--- tb/dup_checker.sv
`timescale 1ns/1ns
// =====
// port-level checks of the i/o port block
module dup_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // watched ports
  input wire dup_pkg::dup_bus_t bus_in,
  input wire logic [7:0] bus_data_out,
  input wire logic bus_data_oe_n,
  input wire logic [5:0] in_pin,
  input wire logic [7:0] out_pin_o,
  input wire logic [7:0] out_pin_oe_n,
  input wire logic [7:0] status_sel,
  input wire logic [7:0] status_act,
  input wire logic chan_a_clear_to_send_n,
  input wire dup_pkg::dup_ext_clk_t ext_clk,
  input wire logic [2:0] counter_mode,
  input wire logic in_change_irq
);
  import dup_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  // the range absorbs the two-flop sync on the bus pins
  property p_set;
    !bus_in.cs_n && $fell(bus_in.wr_n) && bus_in.addr == ADDR_OP_SET |->
      ##[2:5] (out_pin_o & ~status_sel & bus_in.data) == 8'h00;
  endproperty
  a_set: assert property (p_set) else $error("set missed");
  property p_clr;
    !bus_in.cs_n && $fell(bus_in.wr_n) && bus_in.addr == ADDR_OP_CLR |->
      ##[2:5] (~out_pin_o & ~status_sel & bus_in.data) == 8'h00;
  endproperty
  a_clr: assert property (p_clr) else $error("clear missed");
  property p_rst;
    $rose(resetn) |-> out_pin_o == 8'hff && !in_change_irq;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  // pins are held still around every read
  property p_levels;
    $fell(bus_data_oe_n) && bus_in.addr == ADDR_CHG_AUX |->
      bus_data_out[3:0] == in_pin[3:0];
  endproperty
  a_levels: assert property (p_levels) else $error("levels");
  property p_rd_clear;
    in_change_irq && $fell(bus_data_oe_n) && bus_in.addr == ADDR_CHG_AUX
      |-> ##[1:3] !in_change_irq;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("no clear");
  property p_open_drain;
    $stable(status_sel) && $stable(status_act) |->
      (((out_pin_oe_n ^ ~status_act) | out_pin_o) & status_sel) == 8'h00;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("drain");
  // a released send line can only follow a recently high pin
  property p_cts;
    chan_a_clear_to_send_n |-> $past(in_pin[0], 3) || $past(in_pin[0], 4);
  endproperty
  a_cts: assert property (p_cts) else $error("cts");
  property p_ct_sel;
    $past(resetn) && $stable(counter_mode) |->
      ext_clk.ct_sel == (counter_mode == CT_EXT_CODE);
  endproperty
  a_ct_sel: assert property (p_ct_sel) else $error("ct sel");
endmodule

bind dup_ports dup_checker dup_checker_inst (.mclk, .resetn, .bus_in,
  .bus_data_out, .bus_data_oe_n, .in_pin, .out_pin_o, .out_pin_oe_n,
  .status_sel, .status_act, .chan_a_clear_to_send_n, .ext_clk,
  .counter_mode, .in_change_irq);

//--- tb/dup_pin_model.sv
`timescale 1ns/1ns
// =====
// far side: input pins, detector tick and output pull-ups
module dup_pin_model #(
  parameter int TICK_DIV = 20
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // pin levels asked for by the bench
  input wire logic [5:0] pin_req,
  output logic [5:0] in_pin,
  output logic baud_tick_38k4,
  // output pins and the resolved board level
  input wire logic [7:0] out_pin_o,
  input wire logic [7:0] out_pin_oe_n,
  output logic [7:0] out_wire
);
  int cnt = 0;
  // tick period shortened so detector tests stay brief
  always @(posedge mclk) begin
    cnt <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
    baud_tick_38k4 <= resetn && cnt == 0;
  end
  assign in_pin = pin_req;
  // a released pin floats high through its pull-up
  assign out_wire = out_pin_oe_n | out_pin_o;
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import dup_pkg::*;
  // =====
  // stimulus, observed ports and bookkeeping
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic pkg_reduced = 1'b0;
  dup_bus_t bus_in = BUS_IDLE;
  logic [5:0] pin_req = PIN_IDLE;
  logic [7:0] status_sel = 8'h00;
  logic [7:0] status_act = 8'h00;
  logic [5:0] in_pin;
  logic baud_tick_38k4, bus_data_oe_n, baud_set_sel, in_change_irq, sel, x1;
  logic chan_a_clear_to_send_n, chan_b_clear_to_send_n;
  logic [7:0] bus_data_out, out_pin_o, out_pin_oe_n, out_wire, output_port_latch, d;
  logic [2:0] counter_mode;
  logic [3:0] codes[3] = '{4'he, 4'hf, 4'h5};
  dup_ext_clk_t ext_clk;
  logic [7:0] exp_q[$];
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;

  // free-running clock
  always #5 mclk = ~mclk;

  // =====
  // block and far side
  dup_ports dup_ports_inst (.mclk, .resetn, .bus_in, .bus_data_out,
    .bus_data_oe_n, .in_pin, .pkg_reduced, .out_pin_o, .out_pin_oe_n,
    .status_sel, .status_act, .baud_tick_38k4, .chan_a_clear_to_send_n,
    .chan_b_clear_to_send_n, .ext_clk, .baud_set_sel, .counter_mode,
    .in_change_irq);
  dup_pin_model dup_pin_model_inst (.mclk, .resetn, .pin_req, .in_pin,
    .baud_tick_38k4, .out_pin_o, .out_pin_oe_n, .out_wire);

  // =====
  // shared tasks
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // strobe held well past the pin sync, then a gap longer than required
  task automatic acc(logic rd, logic [3:0] a, logic [7:0] v);
    bus_in <= '{1'b0, ~rd, rd, a, v};
    repeat (6) @(posedge mclk);
    bus_in <= '{1'b1, 1'b1, 1'b1, a, v};
    repeat (6) @(posedge mclk);
  endtask

  task automatic rd(logic [3:0] a, logic [7:0] v);
    exp_q.push_back(v);
    acc(1'b1, a, 8'h00);
  endtask

  // over three tick periods, so any change is always caught
  task automatic hold(logic [5:0] p);
    pin_req <= p;
    repeat (70) @(posedge mclk);
  endtask

  task automatic end_sim();
    if (mismatches == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // each read answer is matched with the oldest expectation
  always @(negedge bus_data_oe_n) begin
    #1;
    check("read", bus_data_out, exp_q.pop_front());
  end

  // hang guard, well above the expected run length
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      mismatches++;
      end_sim();
    end
  end

  // =====
  // main sequence
  initial begin
    d = 8'($urandom(94));
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    hold(PIN_IDLE);
    // random set and clear commands against a reference latch
    output_port_latch = OPR_RST;
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      acc(1'b0, i[0] ? ADDR_OP_CLR : ADDR_OP_SET, d);
      output_port_latch = i[0] ? output_port_latch & ~d : output_port_latch | d;
      check("opin", out_pin_o, 8'(~output_port_latch));
    end
    // aux fields; the last pass picks the external counter clock
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      if (i == 3) d[6:4] = CT_EXT_CODE;
      acc(1'b0, ADDR_CHG_AUX, d);
      check("aux", {baud_set_sel, counter_mode}, d[7:4]);
      check("ctsel", ext_clk.ct_sel, d[6:4] == CT_EXT_CODE);
    end
    // both external codes and one internal code on every route
    foreach (codes[i]) begin
      acc(1'b0, ADDR_CSR_A, {2{codes[i]}});
      acc(1'b0, ADDR_CSR_B, {2{codes[i]}});
      sel = codes[i] >= CSR_EXT_X16;
      x1 = codes[i] == CSR_EXT_X1;
      hold(6'h00);
      check("eclk0", ext_clk, {2'b01, {4{1'b0, sel, x1}}});
      hold(PIN_IDLE);
      check("eclk1", ext_clk, {2'b11, {4{sel, sel, x1}}});
    end
    // first mode write goes to mode one, the next enables send control
    acc(1'b0, ADDR_MODE_A, 8'h00);
    acc(1'b0, ADDR_MODE_A, 8'h10);
    acc(1'b0, ADDR_MODE_B, 8'h00);
    acc(1'b0, ADDR_MODE_B, 8'h10);
    for (int i = 0; i < 2; i++) begin
      hold({4'hf, i[0], ~i[0]});
      check("cts_a", chan_a_clear_to_send_n, !i[0]);
      check("cts_b", chan_b_clear_to_send_n, i[0]);
    end
    hold(PIN_IDLE);
    acc(1'b0, ADDR_MODE_A, 8'h00);
    check("cts_off", chan_a_clear_to_send_n, 1'b0);
    // flags from the pin activity above, then read-to-clear
    rd(ADDR_CHG_AUX, 8'hff);
    rd(ADDR_CHG_AUX, 8'h0f);
    acc(1'b0, ADDR_IMASK, 8'h80);
    acc(1'b0, ADDR_CHG_AUX, 8'h02);
    // walk one low pin over 0 to 4; pin 4 has no detector
    for (int k = 0; k < 5; k++) begin
      d = 8'h01 << k;
      hold(PIN_IDLE ^ d[5:0]);
      check("irq", in_change_irq, k == 1);
      rd(ADDR_CHG_AUX, {d[3:0], ~d[3:0]});
      check("irq_rd", in_change_irq, 1'b0);
      rd(ADDR_IN_PORT, {2'b00, PIN_IDLE ^ d[5:0]});
      hold(PIN_IDLE);
      rd(ADDR_CHG_AUX, {d[3:0], 4'hf});
    end
    // the global mask hides the change until it is set again
    acc(1'b0, ADDR_IMASK, 8'h00);
    hold(6'h3d);
    check("irq_mask", in_change_irq, 1'b0);
    acc(1'b0, ADDR_IMASK, 8'h80);
    check("irq_on", in_change_irq, 1'b1);
    rd(ADDR_CHG_AUX, 8'h2d);
    // status pin 4 as open drain against the pull-up
    status_sel <= 8'h10;
    for (int i = 0; i < 2; i++) begin
      status_act <= {3'b000, i[0], 4'h0};
      repeat (3) @(posedge mclk);
      check("od_en", out_pin_oe_n[4], !i[0]);
      check("od_wire", out_wire[4], !i[0]);
    end
    // mid-run reset with the reduced strap: only pin 2 stays bonded
    resetn <= 1'b0;
    pkg_reduced <= 1'b1;
    status_sel <= 8'h00;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    hold(6'h04);
    check("rst_op", out_pin_o, 8'hff);
    acc(1'b0, ADDR_CSR_A, 8'hff);
    acc(1'b0, ADDR_CSR_B, 8'hff);
    check("red_clk", ext_clk, {5'h1f, {3{3'h1}}});
    rd(ADDR_IN_PORT, 8'h3f);
    end_sim();
  end
endmodule
